/* File: core/wbp_cfg.svh */
// Constants of the weapons bus packetizer: field positions, fixed values, timing
// Included by the gap timer and packetizer modules; no logic here
`ifndef WBP_CFG_SVH
`define WBP_CFG_SVH
`define WBP_TS_BITS 48
`define WBP_LEN_BYTES 16'h0018
`define WBP_WORDS_PER_TRANS 6
`define WBP_ST_TE 15
`define WBP_ST_RE 14
`define WBP_ST_TM 13
`define WBP_ST_SE 6
`define WBP_ST_EE 3
`define WBP_F_BUS_HI 15
`define WBP_F_BUS_LO 13
`define WBP_F_GAP_HI 12
`define WBP_F_GAP_LO 10
`define WBP_F_MAN 9
`define WBP_F_PAR 8
`define WBP_CLK_MHZ 20
`define WBP_US_CYC `WBP_CLK_MHZ
`define WBP_GAP_BASE_US 2
`define WBP_GAP_STEP_US 2
`endif

/* File: core/wbp_pkg.sv */
// Types shared by the packetizer modules
// Assumes wbp_cfg.svh is on the include path
package wbp_pkg;
    typedef enum logic [2:0] {
        WBP_BUS_INCOMPLETE = 3'h0,
        WBP_BUS_RESP_B = 3'h1,
        WBP_BUS_RESP_A = 3'h2,
        WBP_BUS_RESP_AB = 3'h3,
        WBP_BUS_RIGHT_B = 3'h4,
        WBP_BUS_RIGHT_A = 3'h5,
        WBP_BUS_LEFT_B = 3'h6,
        WBP_BUS_LEFT_A = 3'h7
    } wbp_bus_t;
    typedef logic [2:0] wbp_gap_t;
endpackage

/* File: core/wbp_gap_timer.sv */
// Inter-word gap timer: counts microseconds from parity mid-crossing to sync mid-crossing
// Assumes both marks are single-cycle pulses on core_clk_i
`timescale 1ns/10ps
`include "wbp_cfg.svh"
module wbp_gap_timer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic parity_mark_i,
    input wire logic sync_mark_i,
    output wbp_pkg::wbp_gap_t gap_code_o
);
    import wbp_pkg::*;
    logic [4:0] cyc;
    logic [7:0] us_count;
    logic armed;
    wire cyc_wrap = (cyc == 5'(`WBP_US_CYC - 1));
    // Bands of 1.6 us approximated in whole microseconds above 1.15 us
    wire [2:0] band = (us_count < 8'd1) ? 3'h0 :
                      (us_count < 8'd3) ? 3'h1 :
                      (us_count < 8'd4) ? 3'h2 :
                      (us_count < 8'd6) ? 3'h4 :
                      (us_count < 8'd8) ? 3'h5 :
                      (us_count < 8'd10) ? 3'h6 : 3'h7;
    wire [2:0] next_code = armed ? band : 3'h0;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cyc <= 5'h0;
            us_count <= 8'h0;
            armed <= 1'b0;
            gap_code_o <= 3'h0;
        end else begin
            if (sync_mark_i) begin
                gap_code_o <= next_code;
                armed <= 1'b0;
            end
            if (parity_mark_i) begin
                // Start counting in 1 us units
                armed <= 1'b1;
                cyc <= 5'h0;
                us_count <= 8'h0;
            end else if (armed) begin
                cyc <= cyc_wrap ? 5'h0 : cyc + 5'h1;
                if (cyc_wrap && us_count != 8'hff) begin
                    us_count <= us_count + 8'h1;
                end
            end
        end
    end
    a_gap_idle_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (sync_mark_i && !armed && !parity_mark_i) |=> gap_code_o == 3'h0)
        else $error("gap code not zero without prior word");
    a_gap_long_max: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (sync_mark_i && armed && us_count >= 8'd10) |=> gap_code_o == 3'h7)
        else $error("long gap not coded 7");
endmodule

/* File: core/wbp_packetizer.sv */
// Weapons bus packetizer: turns monitored six-word transactions into 16-bit recorder words
// Assumes a bus monitor that presents each decoded 26-bit word with flags as a one-cycle strobe
`timescale 1ns/10ps
`include "wbp_cfg.svh"
module wbp_packetizer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [47:0] rel_time_i,
    input wire logic word_valid_i,
    input wire logic [25:0] word_bits_i,
    input wire wbp_pkg::wbp_bus_t word_bus_i,
    input wire logic word_man_err_i,
    input wire logic word_par_err_i,
    input wire logic parity_mark_i,
    input wire logic sync_mark_i,
    input wire logic trans_done_i,
    input wire logic transaction_error_flag_i,
    input wire logic master_reset_flag_i,
    input wire logic message_timeout_flag_i,
    input wire logic status_missing_flag_i,
    input wire logic echo_missing_flag_i,
    input wire logic packet_close_i,
    output logic out_valid_o,
    output logic [15:0] out_word_o,
    output logic out_tally_o,
    output logic [31:0] transaction_tally_o,
    output logic busy_o
);
    import wbp_pkg::*;
    typedef enum logic [1:0] {WBP_COLLECT, WBP_EMIT, WBP_TALLY} wbp_state_t;
    wbp_state_t state;
    logic [15:0] slot [0:11];
    logic [2:0] word_idx;
    logic [47:0] stamp;
    logic [15:0] status;
    logic [4:0] emit_idx;
    logic [31:0] tally;
    logic tally_half;
    wbp_gap_t gap_code;
    wbp_gap_timer u_gap (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .parity_mark_i(parity_mark_i),
        .sync_mark_i(sync_mark_i),
        .gap_code_o(gap_code)
    );
    // Gap code of a word is ready one cycle after its sync mark; monitor strobes later
    wire [15:0] first_half = {word_bus_i, gap_code, word_man_err_i, word_par_err_i,
                              word_bits_i[24:17]};
    wire [15:0] second_half = word_bits_i[16:1];
    wire [15:0] next_status = {transaction_error_flag_i, master_reset_flag_i, message_timeout_flag_i,
                               6'h0, status_missing_flag_i, 2'h0, echo_missing_flag_i, 3'h0};
    wire take_word = (state == WBP_COLLECT) && word_valid_i && (word_idx < 3'(`WBP_WORDS_PER_TRANS));
    wire [3:0] slot_hi = {word_idx, 1'b0};
    wire [3:0] slot_lo = {word_idx, 1'b1};
    wire [63:0] stamp64 = {16'h0, stamp};
    // Stamp LSB first, status, length, then halves in arrival order
    wire [15:0] next_out = (emit_idx < 5'd4) ? stamp64[emit_idx[1:0]*16 +: 16] :
                           (emit_idx == 5'd4) ? status :
                           (emit_idx == 5'd5) ? `WBP_LEN_BYTES : slot[4'(emit_idx - 5'd6)];
    wire emit_last = (emit_idx == 5'd17);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= WBP_COLLECT;
            word_idx <= 3'h0;
            stamp <= 48'h0;
            status <= 16'h0;
            emit_idx <= 5'h0;
            tally <= 32'h0;
            tally_half <= 1'b0;
            out_valid_o <= 1'b0;
            out_word_o <= 16'h0;
            out_tally_o <= 1'b0;
            transaction_tally_o <= 32'h0;
            busy_o <= 1'b0;
            for (int i = 0; i < 12; i++) begin
                slot[i] <= 16'h0;
            end
        end else begin
            out_valid_o <= 1'b0;
            out_tally_o <= 1'b0;
            unique case (state)
                WBP_COLLECT: begin
                    if (take_word) begin
                        if (word_idx == 3'h0) begin
                            stamp <= rel_time_i;
                        end
                        slot[slot_hi] <= first_half;
                        slot[slot_lo] <= second_half;
                        word_idx <= word_idx + 3'h1;
                    end
                    if (trans_done_i) begin
                        // Missing words stay zero-filled so a transaction is always six words
                        status <= next_status;
                        emit_idx <= 5'h0;
                        busy_o <= 1'b1;
                        state <= WBP_EMIT;
                    end else if (packet_close_i) begin
                        tally_half <= 1'b0;
                        busy_o <= 1'b1;
                        state <= WBP_TALLY;
                    end
                end
                WBP_EMIT: begin
                    out_valid_o <= 1'b1;
                    out_word_o <= next_out;
                    emit_idx <= emit_idx + 5'h1;
                    if (emit_last) begin
                        // Every emitted transaction counts toward the tally, short ones included
                        tally <= tally + 32'h1;
                        word_idx <= 3'h0;
                        for (int i = 0; i < 12; i++) begin
                            slot[i] <= 16'h0;
                        end
                        busy_o <= 1'b0;
                        state <= WBP_COLLECT;
                    end
                end
                WBP_TALLY: begin
                    // Tally given as a 32-bit word and as low then high halves
                    out_tally_o <= 1'b1;
                    out_word_o <= tally_half ? tally[31:16] : tally[15:0];
                    transaction_tally_o <= tally;
                    tally_half <= 1'b1;
                    if (tally_half) begin
                        tally <= 32'h0;
                        busy_o <= 1'b0;
                        state <= WBP_COLLECT;
                    end
                end
            endcase
        end
    end
    a_length_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd5) |=> out_word_o == 16'h0018)
        else $error("length word not 24");
    a_stamp_top_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd3) |=> out_word_o == 16'h0)
        else $error("stamp upper bits not zero");
    // First word is visible two edges after the done pulse
    a_emit_length_18: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_COLLECT && trans_done_i) |=> ##1 out_valid_o [*8] ##1 out_valid_o [*8] ##1 out_valid_o [*2]
        ##1 !out_valid_o)
        else $error("transaction not eighteen words");
    a_stamp_latch: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (take_word && word_idx == 3'h0) |=> stamp == $past(rel_time_i))
        else $error("stamp not latched at first word");
    a_first_half_map: assert property (@(posedge core_clk_i) disable iff (rst_i)
        take_word |=> slot[$past(slot_hi)][7:0] == $past(word_bits_i[24:17]))
        else $error("address bits misplaced");
    a_second_half_map: assert property (@(posedge core_clk_i) disable iff (rst_i)
        take_word |=> slot[$past(slot_lo)] == $past(word_bits_i[16:1]))
        else $error("data bits misplaced");
    a_err_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
        take_word |=> slot[$past(slot_hi)][9:8] == $past({word_man_err_i, word_par_err_i}))
        else $error("word error flags wrong");
    a_tally_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_last) |=> tally == $past(tally) + 32'h1)
        else $error("tally not incremented");
    a_status_bits: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd4) |=> (out_word_o & 16'h1fb7) == 16'h0)
        else $error("reserved status bits set");
    a_bus_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
        take_word |=> slot[$past(slot_hi)][15:13] == $past(word_bus_i))
        else $error("source bus code misplaced");
    a_gap_field: assert property (@(posedge core_clk_i) disable iff (rst_i)
        take_word |=> slot[$past(slot_hi)][12:10] == $past(gap_code))
        else $error("gap code misplaced");
    a_first_cmd_slot: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (take_word && word_idx == 3'h0) |=> slot[0][7:0] == $past(word_bits_i[24:17]))
        else $error("first command not in first slot");
    a_stamp_low_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd0) |=> out_word_o == $past(stamp[15:0]))
        else $error("stamp low word not first");
    a_stamp_high_word: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd2) |=> out_word_o == $past(stamp[47:32]))
        else $error("stamp bits 47-32 misplaced");
    a_status_word: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd4) |=> out_word_o == $past(status))
        else $error("status word not after stamp");
    a_status_capture: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_COLLECT && trans_done_i) |=> {status[15:13], status[6], status[3]} ==
        $past({transaction_error_flag_i, master_reset_flag_i, message_timeout_flag_i, status_missing_flag_i,
        echo_missing_flag_i}))
        else $error("status flags not captured");
    a_upper_half_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd6) |=> out_word_o == $past(slot[0]))
        else $error("first word upper half not first");
    a_lower_half_next: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_EMIT && emit_idx == 5'd7) |=> out_word_o == $past(slot[1]))
        else $error("first word lower half not second");
    a_tally_low_half: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_TALLY && !tally_half) |=> out_tally_o && out_word_o == $past(tally[15:0]))
        else $error("tally low half wrong");
    a_tally_high_half: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state == WBP_TALLY && tally_half) |=> out_tally_o && out_word_o == $past(tally[31:16]) && tally == 32'h0)
        else $error("tally high half wrong or not cleared");
    a_busy_tracks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        busy_o == (state != WBP_COLLECT))
        else $error("busy flag out of step with state");
    a_word_cap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        word_idx <= 3'(`WBP_WORDS_PER_TRANS))
        else $error("more than six words taken");
    a_valid_emit_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state != WBP_EMIT) |=> !out_valid_o)
        else $error("word strobe outside emission");
    a_stamp_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state != WBP_COLLECT) |=> $stable(stamp))
        else $error("stamp moved while busy");
endmodule

/* File: testbench/wbp_mon_model.sv */
// Bus monitor model: presents decoded words with sync and parity marks
// Assumes the bench calls send_word after a rising edge plus 5 ns
`timescale 1ns/10ps
module wbp_mon_model (
    input wire logic core_clk_i,
    output logic word_valid_o,
    output logic [25:0] word_bits_o,
    output wbp_pkg::wbp_bus_t word_bus_o,
    output logic word_man_err_o,
    output logic word_par_err_o,
    output logic parity_mark_o,
    output logic sync_mark_o
);
    import wbp_pkg::*;
    initial begin
        {word_valid_o, word_bits_o, word_man_err_o, word_par_err_o, parity_mark_o, sync_mark_o} = '0;
        word_bus_o = WBP_BUS_INCOMPLETE;
    end
    // Gap in cycles from the last parity mark to this sync mark
    task automatic send_word(input logic [25:0] b, input logic [2:0] bus, input logic m, input logic p, input int gap);
        repeat (gap) @(posedge core_clk_i);
        #5 sync_mark_o = 1'b1;
        @(posedge core_clk_i) #5 sync_mark_o = 1'b0;
        @(posedge core_clk_i) #5 word_valid_o = 1'b1;
        {word_bits_o, word_man_err_o, word_par_err_o} = {b, m, p};
        word_bus_o = wbp_bus_t'(bus);
        @(posedge core_clk_i) #5 word_valid_o = 1'b0;
        // Released lines show the inverse so stale data never looks valid
        {word_bits_o, word_man_err_o, word_par_err_o} = {~b, ~m, ~p};
        word_bus_o = wbp_bus_t'(~bus);
        parity_mark_o = 1'b1;
        @(posedge core_clk_i) #5 parity_mark_o = 1'b0;
    endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench of the packetizer with a behavioural reference model
// Assumes wbp_cfg.svh on the include path and the monitor model beside it
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import wbp_pkg::*;
    logic core_clk_i = 0, rst_i = 1, trans_done_i = 0, packet_close_i = 0;
    logic [4:0] fl = '0;
    logic [47:0] rel_time_i = 48'hfedc_ba98_0000;
    logic wv, me, pe, pm, sm, out_valid_o, out_tally_o, busy_o;
    logic [25:0] wb;
    wbp_bus_t bus;
    logic [15:0] out_word_o, slot [0:11], expq[$];
    logic [31:0] transaction_tally_o, exp_tally, s = 32'd65;
    logic [47:0] stamp;
    logic [2:0] gcode;
    logic [15:0] e;
    int miscompares = 0, compares = 0, cyc = 0, cnt = 0, nw = 0, ntr = 0, td = 0, k = 0, armed = 0, th = 0;
    int gaps[7] = '{10, 59, 70, 100, 140, 180, 240};
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        #5 rel_time_i = rel_time_i + 48'h1;
    end
    wbp_mon_model mon (.core_clk_i(core_clk_i), .word_valid_o(wv), .word_bits_o(wb), .word_bus_o(bus),
        .word_man_err_o(me), .word_par_err_o(pe), .parity_mark_o(pm), .sync_mark_o(sm));
    wbp_packetizer DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .rel_time_i(rel_time_i), .word_valid_i(wv),
        .word_bits_i(wb), .word_bus_i(bus), .word_man_err_i(me), .word_par_err_i(pe), .parity_mark_i(pm),
        .sync_mark_i(sm), .trans_done_i(trans_done_i), .transaction_error_flag_i(fl[4]),
        .master_reset_flag_i(fl[3]), .message_timeout_flag_i(fl[2]), .status_missing_flag_i(fl[1]),
        .echo_missing_flag_i(fl[0]), .packet_close_i(packet_close_i), .out_valid_o(out_valid_o),
        .out_word_o(out_word_o), .out_tally_o(out_tally_o), .transaction_tally_o(transaction_tally_o),
        .busy_o(busy_o));
    function automatic logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [2:0] gap_of(input int us);
        return us < 1 ? 3'h0 : us < 3 ? 3'h1 : us < 4 ? 3'h2 : us < 6 ? 3'h4 : us < 8 ? 3'h5 : us < 10 ? 3'h6 : 3'h7;
    endfunction
    // Reference model sampled on every rising edge
    always @(posedge core_clk_i) begin
        cyc++;
        cnt++;
        if (cyc > 20000) begin
            miscompares++;
            tally_and_finish();
        end else if (rst_i) begin
            {armed, nw, ntr} = '0;
            gcode = 3'h0;
        end else begin
            // Whole microseconds elapsed before the sync edge itself
            if (sm) gcode = armed ? gap_of((cnt - 1) / 20) : 3'h0;
            if (pm) begin
                armed = 1;
                cnt = 0;
            end
            if (wv && !busy_o && nw < 6) begin
                if (nw == 0) stamp = rel_time_i;
                slot[2 * nw] = {bus, gcode, me, pe, wb[24:17]};
                slot[2 * nw + 1] = wb[16:1];
                nw++;
            end
            if (out_tally_o) begin
                `CHK(out_word_o, th ? exp_tally[31:16] : exp_tally[15:0])
                th = !th;
            end
            if (out_valid_o) begin
                e = expq.pop_front();
                `CHK(out_word_o, e)
                `CHK(cyc - td, k + 2)
                k++;
            end
            if (trans_done_i && !busy_o) begin
                expq.push_back(stamp[15:0]);
                expq.push_back(stamp[31:16]);
                expq.push_back(stamp[47:32]);
                expq.push_back(16'h0000);
                expq.push_back({fl[4:2], 6'h00, fl[1], 2'h0, fl[0], 3'h0});
                expq.push_back(16'h0018);
                for (int i = 0; i < 12; i++) expq.push_back(i < 2 * nw ? slot[i] : 16'h0000);
                {nw, k} = '0;
                td = cyc;
                ntr++;
            end
            if (packet_close_i && !busy_o && !trans_done_i) begin
                exp_tally = ntr;
                ntr = 0;
            end
        end
    end
    task automatic trans(input int n, input int t);
        logic [31:0] r;
        int j;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            mon.send_word(r[25:0], r[28:26], r[29], r[30], gaps[(t + i) % 7]);
        end
        @(posedge core_clk_i) #5 trans_done_i = 1'b1;
        fl = 5'(rnd());
        @(posedge core_clk_i) #5 trans_done_i = 1'b0;
        j = 0;
        while (busy_o === 1'b1 && j < 40) begin
            @(posedge core_clk_i) #5 j++;
        end
        `CHK(busy_o, 1'b0)
    endtask
    task automatic close_check();
        @(posedge core_clk_i) #5 packet_close_i = 1'b1;
        @(posedge core_clk_i) #5 packet_close_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #5 `CHK(transaction_tally_o, exp_tally)
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk_i);
        #5 rst_i = 1'b0;
        `CHK(busy_o, 1'b0)
        // Short, full and overlong transactions, gap bands rotating
        for (int t = 0; t < 7; t++) trans(t == 2 ? 3 : t == 4 ? 7 : 6, t);
        close_check();
        close_check();
        trans(6, 3);
        close_check();
        `CHK(expq.size(), 0)
        tally_and_finish();
    end
endmodule
